// ---- serial_flash_security_buffer_cmds_tb.sv ----
`timescale 1ns/1ps
module serial_flash_security_buffer_cmds_tb;
	localparam logic [7:0] SEED = 8'h5A; // arbitrary factory pattern
	logic clk_sys, reset, page_256, so, so_oe, ready, cmp_mis, permit, otp_used, lock_cmd;
	wire spi_clk, cs_n, si;
	wire so_w;
	logic [10:0] arr_page;
	logic [8:0] arr_byte;
	logic [7:0] arr_rdata;
	logic [7:0] sec_exp[128];
	logic [7:0] tx[$];
	int n_mismatch, n_tests, busy_cnt, lock_cnt;
	assign so_w = so_oe ? so : 1'bz;
	// array content depends on the low eight bits of page and byte, so only pages that differ in bits 7:0 differ
	assign arr_rdata = arr_page[7:0] ^ arr_byte[7:0] ^ 8'h3C;
	sfs_top #(.FREEZE_CYC(20), .PROG_CYC(20), .COPY_CYC(300), .COMP_CYC(300),
		.FACTORY_SEED(SEED)) dut (.CLK_SYS(clk_sys), .RESET(reset), .SPI_CLK(spi_clk),
		.CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe), .PAGE_256(page_256),
		.ARR_PAGE(arr_page), .ARR_BYTE(arr_byte), .ARR_RDATA(arr_rdata), .READY(ready),
		.COMPARE_MISMATCH(cmp_mis), .LOCKDOWN_PERMIT(permit), .SEC_OTP_USED(otp_used),
		.LOCK_CMD(lock_cmd));
	sfs_host host (.cs_n(cs_n), .spi_clk(spi_clk), .si(si), .so(so_w));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (ready === 1'b0) busy_cnt++;
		if (lock_cmd === 1'b1) lock_cnt++;
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	task automatic settle();
		int k;
		k = 0;
		repeat (6) @(posedge clk_sys);
		while (ready !== 1'b1 && k < 1000) begin
			@(posedge clk_sys);
			k++;
		end
		check(ready, 1'b1, "ready back");
		#2;
	endtask
	task automatic cmd(input logic [7:0] q[$]);
		busy_cnt = 0;
		host.frame(q, 0);
		settle();
	endtask
	task automatic pgframe(input logic [7:0] opc, input logic [10:0] pg);
		logic [23:0] a;
		a = page_256 ? {5'h00, pg, 8'h00} : {4'h0, pg, 9'h000};
		host.frame({opc, a[23:16], a[15:8], a[7:0]}, 0);
	endtask
	task automatic pgop(input logic [7:0] opc, input logic [10:0] pg);
		busy_cnt = 0;
		pgframe(opc, pg);
		check(arr_page, pg, "page index");
		settle();
		check(busy_cnt, 300, "busy length");
	endtask
	task automatic read_sec();
		host.frame({8'h77, 8'h00, 8'h00, 8'h00}, 128);
		for (int i = 0; i < 128; i++) check(host.rxq[i+4], sec_exp[i], "sec byte");
		check(so_oe, 1'b0, "output released");
	endtask
	initial begin
		#2000000;
		n_mismatch++;
		$display("BAD %0t watchdog expired", $time);
		complete_run();
	end
	initial begin
		reset = 1'b1;
		page_256 = 1'b0;
		busy_cnt = 0;
		lock_cnt = 0;
		for (int i = 0; i < 128; i++) sec_exp[i] = (i < 64) ? 8'hFF : (8'(i) ^ SEED);
		repeat (3) @(posedge clk_sys);
		#2 reset = 1'b0;
		repeat (4) @(posedge clk_sys);
		#2;
		check(ready, 1'b1, "ready at reset");
		check(permit, 1'b1, "permit at reset");
		check(otp_used, 1'b0, "otp at reset");
		check(so_oe, 1'b0, "output idle");
		read_sec();
		$display("test reset and factory read done");
		pgop(8'h53, 11'h5A3);
		pgop(8'h60, 11'h5A3);
		check(cmp_mis, 1'b0, "compare equal");
		pgop(8'h60, 11'h2B1);
		check(cmp_mis, 1'b1, "compare differ");
		busy_cnt = 0;
		pgframe(8'h53, 11'h0F0);
		pgframe(8'h53, 11'h5A3);
		settle();
		check(busy_cnt, 300, "second op refused");
		pgop(8'h60, 11'h0F0);
		check(cmp_mis, 1'b0, "buffer kept first copy");
		$display("test copy and compare 264 done");
		page_256 = 1'b1;
		repeat (4) @(posedge clk_sys);
		pgop(8'h55, 11'h3C7);
		pgop(8'h61, 11'h3C7);
		check(cmp_mis, 1'b0, "buffer 2 equal");
		pgop(8'h60, 11'h3C7);
		check(cmp_mis, 1'b1, "buffer 1 differs");
		page_256 = 1'b0;
		$display("test 256 mode done");
		pgop(8'h53, 11'h5A3);
		tx = {8'h9B, 8'h00, 8'h00, 8'h00};
		for (int n = 0; n < 64; n++) tx.push_back(8'h10 + 8'(n));
		tx.push_back(8'hC3);
		cmd(tx);
		check(busy_cnt, 20, "program busy");
		check(otp_used, 1'b1, "otp used");
		for (int n = 0; n < 64; n++) sec_exp[n] = 8'h10 + 8'(n);
		sec_exp[0] = 8'hC3;
		read_sec();
		pgop(8'h60, 11'h5A3);
		check(cmp_mis, 1'b1, "buffer 1 overwritten");
		for (int n = 4; n < 68; n++) tx[n] = 8'h00;
		cmd(tx);
		check(busy_cnt, 0, "second program ignored");
		read_sec();
		$display("test security program done");
		lock_cnt = 0;
		cmd({8'h3D, 8'h2A, 8'h7F, 8'h30, 8'h01, 8'h00, 8'h00});
		check(lock_cnt, 1, "lockdown passed on");
		cmd({8'h34, 8'h55, 8'hAA, 8'h41});
		check(busy_cnt, 0, "near freeze ignored");
		check(permit, 1'b1, "permit kept");
		cmd({8'h34, 8'h55, 8'hAA, 8'h40, 8'h77, 8'h53, 8'h00, 8'h00});
		check(busy_cnt, 20, "freeze busy");
		check(permit, 1'b0, "permit cleared");
		lock_cnt = 0;
		cmd({8'h3D, 8'h2A, 8'h7F, 8'h30, 8'h01, 8'h00, 8'h00});
		check(lock_cnt, 0, "lockdown blocked");
		$display("test freeze done");
		complete_run();
	end
endmodule

// ---- sfs_host.sv ----
`timescale 1ns/1ps
module sfs_host (
	// serial lines toward the device
	output logic cs_n,
	output logic spi_clk,
	output logic si,
	// resolved data line from the device
	input wire logic so
);
	localparam int HALF = 32;
	logic [7:0] rxq[$];
	initial begin
		cs_n = 1'b1;
		spi_clk = 1'b0;
		si = 1'b0;
	end
	// mode 0: data set while the clock is low, both sides sample on the rise
	task automatic xbyte(input logic [7:0] b);
		logic [7:0] r;
		for (int i = 7; i >= 0; i--) begin
			si = b[i];
			#HALF;
			spi_clk = 1'b1;
			r[i] = so;
			#HALF;
			spi_clk = 1'b0;
		end
		rxq.push_back(r);
	endtask
	// clock only runs while selected, select held over every byte
	task automatic frame(input logic [7:0] tx[$], input int nrd);
		rxq.delete();
		#7;
		cs_n = 1'b0;
		#200;
		foreach (tx[i]) xbyte(tx[i]);
		repeat (nrd) xbyte(8'h00);
		#HALF;
		// a released line must not look like it still carries the last bit
		si = ~si;
		cs_n = 1'b1;
		#200;
	endtask
endmodule

// ---- sfs_link.sv ----
`timescale 1ns/1ps
module sfs_link (
	// serial pins, link clock domain
	input wire logic spi_clk,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	// carrier to the core
	sfs_link_if.link lk
);
	logic [2:0] bit_q;
	logic [6:0] in_q;
	logic [6:0] out_q;

	// the clock stops between frames, so chip select itself restarts the count
	always_ff @(posedge spi_clk or posedge cs_n) begin
		if (cs_n) begin
			bit_q <= 3'h0;
		end else begin
			bit_q <= bit_q + 3'h1;
		end
	end

	always_ff @(posedge spi_clk) begin
		in_q <= {in_q[5:0], si};
	end

	// byte stays put for a whole byte time, long enough for the core to take it
	always_ff @(posedge spi_clk) begin
		if (bit_q == sfs_pkg::BIT_LAST) begin
			lk.rx_byte <= {in_q, si};
		end
	end

	always_ff @(posedge spi_clk or posedge lk.link_rst) begin
		if (lk.link_rst) begin
			lk.rx_tog <= 1'b0;
		end else if (bit_q == sfs_pkg::BIT_LAST) begin
			lk.rx_tog <= ~lk.rx_tog;
		end
	end

	// mode 0 only: output changes on the falling edge, new byte at each boundary
	always_ff @(negedge spi_clk or posedge lk.link_rst) begin
		if (lk.link_rst) begin
			so <= 1'b0;
			out_q <= 7'h00;
			lk.tx_tog <= 1'b0;
		end else if (bit_q == 3'h0) begin
			so <= lk.tx_byte[7];
			out_q <= lk.tx_byte[6:0];
			lk.tx_tog <= ~lk.tx_tog;
		end else begin
			so <= out_q[6];
			out_q <= {out_q[5:0], 1'b0};
		end
	end
endmodule

// ---- sfs_link_if.sv ----
`timescale 1ns/1ps
interface sfs_link_if;
	logic [7:0] rx_byte;
	logic rx_tog;
	logic tx_tog;
	logic [7:0] tx_byte;
	logic link_rst;
	modport link (output rx_byte, output rx_tog, output tx_tog, input tx_byte, input link_rst);
	modport core (input rx_byte, input rx_tog, input tx_tog, output tx_byte, output link_rst);
endinterface

// ---- sfs_pkg.sv ----
package sfs_pkg;
	localparam int CLK_MHZ = 25;
	localparam int FREEZE_US = 200;
	localparam int PROG_US = 400;
	localparam int COPY_US = 200;
	localparam int COMP_US = 200;
	// all four are longest times, so whole cycles round down
	localparam int FREEZE_CYC = FREEZE_US * CLK_MHZ;
	localparam int PROG_CYC = PROG_US * CLK_MHZ;
	localparam int COPY_CYC = COPY_US * CLK_MHZ;
	localparam int COMP_CYC = COMP_US * CLK_MHZ;
	localparam int TMR_W = 24;
	typedef logic [TMR_W-1:0] sfs_tmr_t;
	localparam sfs_tmr_t TMR_ONE = sfs_tmr_t'(1);

	localparam logic [7:0] OPC_FRZ0 = 8'h34;
	localparam logic [7:0] OPC_FRZ1 = 8'h55;
	localparam logic [7:0] OPC_FRZ2 = 8'hAA;
	localparam logic [7:0] OPC_FRZ3 = 8'h40;
	localparam logic [7:0] OPC_LCK0 = 8'h3D;
	localparam logic [7:0] OPC_LCK1 = 8'h2A;
	localparam logic [7:0] OPC_LCK2 = 8'h7F;
	localparam logic [7:0] OPC_LCK3 = 8'h30;
	localparam logic [7:0] OPC_SPROG = 8'h9B;
	localparam logic [7:0] OPC_ZERO = 8'h00;
	localparam logic [7:0] OPC_SREAD = 8'h77;
	localparam logic [7:0] OPC_XFR1 = 8'h53;
	localparam logic [7:0] OPC_XFR2 = 8'h55;
	localparam logic [7:0] OPC_CMP1 = 8'h60;
	localparam logic [7:0] OPC_CMP2 = 8'h61;

	localparam logic [2:0] CMD_LEN = 3'h4;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [7:0] SEC_BYTES = 8'h80;
	localparam int SEC_USER = 64;
	localparam logic [7:0] RD_LEAD = 8'h03;
	localparam logic [7:0] USER_BLANK = 8'hFF;
	localparam logic [8:0] PAGE_STD = 9'h108;
	localparam logic [8:0] PAGE_BIN = 9'h100;
	localparam int PG_W = 11;
	localparam int PG_STD_LSB = 9;
	localparam int PG_BIN_LSB = 8;
	localparam logic PERMIT_RST = 1'b1;

	typedef enum logic [2:0] {OPK_NONE, OPK_FREEZE, OPK_PROG, OPK_XFR, OPK_COMP} sfs_op_t;
endpackage

// ---- sfs_top.sv ----
`timescale 1ns/1ps
module sfs_top #(
	parameter int BUF_BYTES = int'(sfs_pkg::PAGE_STD),
	parameter int FREEZE_CYC = sfs_pkg::FREEZE_CYC,
	parameter int PROG_CYC = sfs_pkg::PROG_CYC,
	parameter int COPY_CYC = sfs_pkg::COPY_CYC,
	parameter int COMP_CYC = sfs_pkg::COMP_CYC,
	// arbitrary value, stands in for the per-part factory data
	parameter logic [7:0] FACTORY_SEED = 8'h5A
) (
	// system clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET,
	// serial link
	input wire logic SPI_CLK,
	input wire logic CS_N,
	input wire logic SI,
	output logic SO,
	output logic SO_OE,
	// configuration strap
	input wire logic PAGE_256,
	// main array read port
	output logic [10:0] ARR_PAGE,
	output logic [8:0] ARR_BYTE,
	input wire logic [7:0] ARR_RDATA,
	// status
	output logic READY,
	output logic COMPARE_MISMATCH,
	output logic LOCKDOWN_PERMIT,
	output logic SEC_OTP_USED,
	output logic LOCK_CMD
);
	typedef enum logic {ST_IDLE, ST_RUN} sfs_state_t;

	sfs_link_if lk ();

	sfs_link u_link (
		.spi_clk(SPI_CLK),
		.cs_n(CS_N),
		.si(SI),
		.so(SO),
		.lk(lk.link)
	);

	logic cs_s1, cs_s2, cs_s3;
	logic rx_s1, rx_s2, rx_s3;
	logic tx_s1, tx_s2, tx_s3;
	logic pg_s1, pg_s2;
	logic rx_evt, tx_evt, cs_fall, cs_rise;
	logic [2:0] nb_q;
	logic [7:0] txn_q;
	logic [7:0] cb_q [0:3];
	logic [5:0] widx_q;
	logic [7:0] buf_q [0:1][0:BUF_BYTES-1];
	logic [7:0] user_q [0:sfs_pkg::SEC_USER-1];
	logic [23:0] addr;
	logic [10:0] page_idx;
	logic [8:0] page_len;
	logic cmd_full, cmd_freeze, cmd_prog, cmd_lock, cmd_read, cmd_xfr, cmd_cmp, sel_b2;
	logic data_we, user_we, start, op_end, walking;
	logic [7:0] sec_idx;
	logic [7:0] sec_byte;
	sfs_state_t st_q;
	sfs_pkg::sfs_op_t op_q, op_d;
	sfs_pkg::sfs_tmr_t timer_q;
	logic sel_q, rd_v_q, mism_q;
	logic [8:0] walk_q;

	// link toggles and pins are foreign to this clock: two flops before use
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			rx_s1 <= 1'b0;
			rx_s2 <= 1'b0;
			rx_s3 <= 1'b0;
			tx_s1 <= 1'b0;
			tx_s2 <= 1'b0;
			tx_s3 <= 1'b0;
			pg_s1 <= 1'b0;
			pg_s2 <= 1'b0;
		end else begin
			cs_s1 <= CS_N;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			rx_s1 <= lk.rx_tog;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			tx_s1 <= lk.tx_tog;
			tx_s2 <= tx_s1;
			tx_s3 <= tx_s2;
			pg_s1 <= PAGE_256;
			pg_s2 <= pg_s1;
		end
	end

	// link toggles are held at zero while reset is on, matching rx_s*/tx_s*
	always_ff @(posedge CLK_SYS) begin
		lk.link_rst <= RESET;
	end

	assign rx_evt = rx_s2 ^ rx_s3;
	assign tx_evt = tx_s2 ^ tx_s3;
	assign cs_fall = cs_s3 & ~cs_s2;
	assign cs_rise = cs_s2 & ~cs_s3;

	// first four bytes of a frame are kept; later ones never touch them
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			nb_q <= 3'h0;
			txn_q <= 8'h00;
			for (int i = 0; i < 4; i++) begin
				cb_q[i] <= 8'h00;
			end
		end else if (cs_fall) begin
			nb_q <= 3'h0;
			txn_q <= 8'h00;
		end else begin
			if (rx_evt && nb_q != sfs_pkg::CMD_LEN) begin
				cb_q[nb_q[1:0]] <= lk.rx_byte;
				nb_q <= nb_q + 3'h1;
			end
			if (tx_evt && txn_q != 8'hFF) begin
				txn_q <= txn_q + 8'h01;
			end
		end
	end

	assign cmd_full = nb_q == sfs_pkg::CMD_LEN;
	assign cmd_freeze = cmd_full && cb_q[0] == sfs_pkg::OPC_FRZ0 && cb_q[1] == sfs_pkg::OPC_FRZ1
		&& cb_q[2] == sfs_pkg::OPC_FRZ2 && cb_q[3] == sfs_pkg::OPC_FRZ3;
	assign cmd_lock = cmd_full && cb_q[0] == sfs_pkg::OPC_LCK0 && cb_q[1] == sfs_pkg::OPC_LCK1
		&& cb_q[2] == sfs_pkg::OPC_LCK2 && cb_q[3] == sfs_pkg::OPC_LCK3;
	assign cmd_prog = cmd_full && cb_q[0] == sfs_pkg::OPC_SPROG && cb_q[1] == sfs_pkg::OPC_ZERO
		&& cb_q[2] == sfs_pkg::OPC_ZERO && cb_q[3] == sfs_pkg::OPC_ZERO;
	assign cmd_read = nb_q != 3'h0 && cb_q[0] == sfs_pkg::OPC_SREAD;
	assign cmd_xfr = cmd_full && (cb_q[0] == sfs_pkg::OPC_XFR1 || cb_q[0] == sfs_pkg::OPC_XFR2);
	assign cmd_cmp = cmd_full && (cb_q[0] == sfs_pkg::OPC_CMP1 || cb_q[0] == sfs_pkg::OPC_CMP2);
	assign sel_b2 = cb_q[0] == sfs_pkg::OPC_XFR2 || cb_q[0] == sfs_pkg::OPC_CMP2;

	assign addr = {cb_q[1], cb_q[2], cb_q[3]};
	assign page_idx = pg_s2 ? addr[sfs_pkg::PG_BIN_LSB +: sfs_pkg::PG_W]
		: addr[sfs_pkg::PG_STD_LSB +: sfs_pkg::PG_W];
	assign page_len = pg_s2 ? sfs_pkg::PAGE_BIN : sfs_pkg::PAGE_STD;

	// data bytes of a security program frame; a busy device ignores them
	assign data_we = rx_evt && cmd_prog && st_q == ST_IDLE;

	always_ff @(posedge CLK_SYS) begin
		if (RESET || cs_fall) begin
			widx_q <= 6'h00;
		end else if (data_we) begin
			widx_q <= widx_q + 6'h01;
		end
	end

	always_comb begin
		op_d = sfs_pkg::OPK_NONE;
		if (cmd_freeze && LOCKDOWN_PERMIT) begin
			op_d = sfs_pkg::OPK_FREEZE;
		end else if (cmd_prog && !SEC_OTP_USED) begin
			op_d = sfs_pkg::OPK_PROG;
		end else if (cmd_xfr) begin
			op_d = sfs_pkg::OPK_XFR;
		end else if (cmd_cmp) begin
			op_d = sfs_pkg::OPK_COMP;
		end
	end

	// nothing starts unless idle, so one operation at a time
	assign start = cs_rise && st_q == ST_IDLE && op_d != sfs_pkg::OPK_NONE;
	assign op_end = st_q == ST_RUN && timer_q == sfs_pkg::TMR_ONE;

	function automatic sfs_pkg::sfs_tmr_t op_cycles(input sfs_pkg::sfs_op_t op);
		case (op)
			sfs_pkg::OPK_FREEZE: op_cycles = sfs_pkg::sfs_tmr_t'(FREEZE_CYC);
			sfs_pkg::OPK_PROG: op_cycles = sfs_pkg::sfs_tmr_t'(PROG_CYC);
			sfs_pkg::OPK_XFR: op_cycles = sfs_pkg::sfs_tmr_t'(COPY_CYC);
			sfs_pkg::OPK_COMP: op_cycles = sfs_pkg::sfs_tmr_t'(COMP_CYC);
			default: op_cycles = sfs_pkg::TMR_ONE;
		endcase
	endfunction

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			st_q <= ST_IDLE;
			op_q <= sfs_pkg::OPK_NONE;
			timer_q <= sfs_pkg::TMR_ONE;
			sel_q <= 1'b0;
			READY <= 1'b1;
			ARR_PAGE <= 11'h000;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (start) begin
						st_q <= ST_RUN;
						op_q <= op_d;
						timer_q <= op_cycles(op_d);
						sel_q <= sel_b2;
						ARR_PAGE <= page_idx;
						READY <= 1'b0;
					end
				end
				ST_RUN: begin
					if (op_end) begin
						st_q <= ST_IDLE;
						op_q <= sfs_pkg::OPK_NONE;
						READY <= 1'b1;
					end else begin
						timer_q <= timer_q - sfs_pkg::TMR_ONE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// page walk: the array answers combinationally for the address on the port,
	// so the walk has to fit in the operation time
	assign walking = st_q == ST_RUN && walk_q < page_len
		&& (op_q == sfs_pkg::OPK_XFR || op_q == sfs_pkg::OPK_COMP);

	always_ff @(posedge CLK_SYS) begin
		if (RESET || start) begin
			walk_q <= 9'h000;
			rd_v_q <= 1'b0;
			ARR_BYTE <= 9'h000;
		end else begin
			rd_v_q <= walking;
			ARR_BYTE <= walk_q;
			if (walking) begin
				walk_q <= walk_q + 9'h001;
			end
		end
	end

	// buffer 1 doubles as staging for the security program data
	always_ff @(posedge CLK_SYS) begin
		if (data_we) begin
			buf_q[0][widx_q] <= lk.rx_byte;
		end else if (rd_v_q && op_q == sfs_pkg::OPK_XFR) begin
			buf_q[sel_q][ARR_BYTE] <= ARR_RDATA;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET || start) begin
			mism_q <= 1'b0;
		end else if (rd_v_q && op_q == sfs_pkg::OPK_COMP && buf_q[sel_q][ARR_BYTE] != ARR_RDATA) begin
			mism_q <= 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			COMPARE_MISMATCH <= 1'b0;
		end else if (op_end && op_q == sfs_pkg::OPK_COMP) begin
			COMPARE_MISMATCH <= mism_q;
		end
	end

	// one-shot user area: written straight from buffer 1, no erase pass
	assign user_we = op_end && op_q == sfs_pkg::OPK_PROG;

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			for (int i = 0; i < sfs_pkg::SEC_USER; i++) begin
				user_q[i] <= sfs_pkg::USER_BLANK;
			end
		end else if (user_we) begin
			for (int i = 0; i < sfs_pkg::SEC_USER; i++) begin
				user_q[i] <= buf_q[0][i];
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			SEC_OTP_USED <= 1'b0;
		end else if (user_we) begin
			SEC_OTP_USED <= 1'b1;
		end
	end

	// permit is cleared only by a finished freeze and never set again
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			LOCKDOWN_PERMIT <= sfs_pkg::PERMIT_RST;
		end else if (op_end && op_q == sfs_pkg::OPK_FREEZE) begin
			LOCKDOWN_PERMIT <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			LOCK_CMD <= 1'b0;
		end else begin
			LOCK_CMD <= cs_rise && st_q == ST_IDLE && cmd_lock && LOCKDOWN_PERMIT;
		end
	end

	// byte k is prepared while the link still shifts the byte before it
	assign sec_idx = txn_q - sfs_pkg::RD_LEAD;
	assign sec_byte = sec_idx[6] ? (sec_idx ^ FACTORY_SEED) : user_q[sec_idx[5:0]];

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			lk.tx_byte <= 8'h00;
		end else if (cmd_read && sec_idx < sfs_pkg::SEC_BYTES) begin
			lk.tx_byte <= sec_byte;
		end else begin
			lk.tx_byte <= 8'h00;
		end
	end

	// enable opens during the last dummy byte; it lags chip select by up to
	// three system cycles when the frame ends
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			SO_OE <= 1'b0;
		end else begin
			SO_OE <= !cs_s2 && cmd_read && txn_q >= sfs_pkg::RD_LEAD;
		end
	end

	property p_permit_sticky;
		@(posedge CLK_SYS) disable iff (RESET) !LOCKDOWN_PERMIT |=> !LOCKDOWN_PERMIT;
	endproperty
	a_permit_sticky: assert property (p_permit_sticky)
		else $error("lockdown permit came back");

	property p_freeze_clears;
		@(posedge CLK_SYS) disable iff (RESET)
			(op_end && op_q == sfs_pkg::OPK_FREEZE) |=> !LOCKDOWN_PERMIT && READY;
	endproperty
	a_freeze_clears: assert property (p_freeze_clears)
		else $error("freeze end did not clear permit");

	property p_lock_ignored;
		@(posedge CLK_SYS) disable iff (RESET) (cs_rise && cmd_lock && !LOCKDOWN_PERMIT) |=> !LOCK_CMD;
	endproperty
	a_lock_ignored: assert property (p_lock_ignored)
		else $error("lockdown passed after freeze");

	property p_otp_once;
		@(posedge CLK_SYS) disable iff (RESET) SEC_OTP_USED |-> !user_we && !(start && op_d == sfs_pkg::OPK_PROG);
	endproperty
	a_otp_once: assert property (p_otp_once)
		else $error("user area programmed twice");

	property p_user_copy;
		@(posedge CLK_SYS) disable iff (RESET) user_we |=> SEC_OTP_USED && user_q[0] == $past(buf_q[0][0]);
	endproperty
	a_user_copy: assert property (p_user_copy)
		else $error("user area not loaded from buffer 1");

	property p_wrap;
		@(posedge CLK_SYS) disable iff (RESET) (data_we && widx_q == 6'h3F && !cs_fall) |=> widx_q == 6'h00;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("data index did not wrap");

	property p_xfr_busy;
		@(posedge CLK_SYS) disable iff (RESET)
			(cs_rise && st_q == ST_IDLE && cmd_xfr) |=> !READY ##1 !READY;
	endproperty
	a_xfr_busy: assert property (p_xfr_busy)
		else $error("copy did not report busy");

	property p_cmp_result;
		@(posedge CLK_SYS) disable iff (RESET)
			(op_end && op_q == sfs_pkg::OPK_COMP) |=> READY && COMPARE_MISMATCH == $past(mism_q);
	endproperty
	a_cmp_result: assert property (p_cmp_result)
		else $error("compare result not posted");

	property p_one_op;
		@(posedge CLK_SYS) disable iff (RESET) (st_q == ST_RUN && !op_end) |=> $stable(op_q) && !READY;
	endproperty
	a_one_op: assert property (p_one_op)
		else $error("operation changed while busy");

	property p_oe_off;
		@(posedge CLK_SYS) disable iff (RESET) $rose(cs_s2) |=> !SO_OE;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("output still enabled after frame");
endmodule
